//--- common/bdmc_map.vh
// register map, field positions, reset values and timing counts of the backlight dimming block
`ifndef BDMC_MAP_VH
`define BDMC_MAP_VH

// register offsets
`define BDMC_OFS_BRIGHT       8'h00
`define BDMC_OFS_CTRL         8'h01
`define BDMC_OFS_STATUS       8'h02
`define BDMC_OFS_CHAN         8'h09

// reset values
`define BDMC_RST_BRIGHT       8'hFF
`define BDMC_RST_CTRL         8'h00

// control register fields
`define BDMC_CTRL_ENABLE      0
`define BDMC_CTRL_SOURCE      1
`define BDMC_CTRL_INTERP      2

// status register fields
`define BDMC_STAT_FAULT       0
`define BDMC_STAT_THERMAL     1
`define BDMC_STAT_OVERCURR    2
`define BDMC_STAT_BL_ON       3

// channel readout when the backlight is on (six channels, all good)
`define BDMC_CHAN_ALL_ON      6'h3F

// bus address of the device (arbitrary value)
`define BDMC_BUS_ADDR         7'h2C

// timing
`define BDMC_CLK_HZ           100000000
`define BDMC_DIM_FREQ_HZ      200
`define BDMC_DIM_STEPS        255
// cycles per dimming step: core clock over dimming frequency times steps, floored
`define BDMC_DIM_TICK_CYC     16'h07A8
`define BDMC_MEAS_SHIFT       12

`endif

//--- hw/bdmc_dim_gen.v
// dimming waveform generator running at the internal dimming frequency
`include "bdmc_map.vh"

module bdmc_dim_gen #(
    parameter [15:0] TICK_CYC = `BDMC_DIM_TICK_CYC
) (
    // clock and reset
    input  wire       i_core_clk,
    input  wire       i_arst_n,
    // duty request, code out of 255
    input  wire [7:0] i_duty,
    // waveform
    output reg        o_wave
);

    reg [15:0] tick_cnt;
    reg [7:0]  step;
    reg [7:0]  duty_frame;

    // duty is latched at frame start so a change mid-frame cannot make a runt pulse
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_cnt   <= 16'h0000;
            step       <= 8'h00;
            duty_frame <= 8'h00;
            o_wave     <= 1'b0;
        end else begin
            if (tick_cnt >= TICK_CYC - 16'h0001) begin
                tick_cnt <= 16'h0000;
                if (step == 8'hFE) begin
                    step       <= 8'h00;
                    duty_frame <= i_duty;
                end else begin
                    step <= step + 8'h01;
                end
            end else begin
                tick_cnt <= tick_cnt + 16'h0001;
            end
            o_wave <= (step < duty_frame);
        end
    end

endmodule

//--- hw/bdmc_pwm_meas.v
// duty measurement of the external dimming input over a fixed window
`include "bdmc_map.vh"

module bdmc_pwm_meas #(
    parameter MEAS_SHIFT = `BDMC_MEAS_SHIFT
) (
    // clock and reset
    input  wire       i_core_clk,
    input  wire       i_arst_n,
    // external dimming input
    input  wire       i_external_dim_input,
    // measured duty, code out of 255
    output reg  [7:0] o_duty
);

    reg [MEAS_SHIFT-1:0] sub_cnt;
    reg [7:0]            step;
    reg [MEAS_SHIFT+7:0] acc;
    wire [MEAS_SHIFT+7:0] acc_sum = acc + {{(MEAS_SHIFT+7){1'b0}}, i_external_dim_input};

    // window is 255 << MEAS_SHIFT cycles; high count >> MEAS_SHIFT is the 0..255 code.
    // the window must span several input periods, or the reading jitters with phase
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sub_cnt <= {MEAS_SHIFT{1'b0}};
            step    <= 8'h00;
            acc     <= {(MEAS_SHIFT+8){1'b0}};
            o_duty  <= 8'hFF;
        end else begin
            sub_cnt <= sub_cnt + {{(MEAS_SHIFT-1){1'b0}}, 1'b1};
            if (&sub_cnt && step == 8'hFE) begin
                step   <= 8'h00;
                o_duty <= acc_sum[MEAS_SHIFT+7:MEAS_SHIFT];
                acc    <= {(MEAS_SHIFT+8){1'b0}};
            end else begin
                if (&sub_cnt)
                    step <= step + 8'h01;
                acc <= acc_sum;
            end
        end
    end

endmodule

//--- hw/bdmc_top.v
// backlight dimming mode control: two-wire register slave, registers and dimming selection
`include "bdmc_map.vh"

module bdmc_top #(
    parameter [15:0] DIM_TICK_CYC = `BDMC_DIM_TICK_CYC,
    parameter        MEAS_SHIFT   = `BDMC_MEAS_SHIFT,
    parameter [6:0]  BUS_ADDR     = `BDMC_BUS_ADDR
) (
    // clock and reset
    input  wire       i_core_clk,
    input  wire       i_arst_n,
    // two-wire host link, data line is open drain
    input  wire       i_scl,
    input  wire       i_sda,
    output wire       o_sda,
    output wire       o_sda_oe_n,
    // external dimming source and fault conditions
    input  wire       i_external_dim_input,
    input  wire       i_thermal_fault,
    input  wire       i_overcurrent,
    // dimming output and state
    output reg        o_dim_out,
    output reg        o_backlight_on_status,
    output reg  [5:0] o_channel_on
);

    // link states
    // the slave never stretches the bus clock, so every state lasts whole bus phases
    localparam [2:0] S_IDLE     = 3'h0;
    localparam [2:0] S_ADDR     = 3'h1;
    localparam [2:0] S_ADDR_ACK = 3'h2;
    localparam [2:0] S_WBYTE    = 3'h3;
    localparam [2:0] S_WACK     = 3'h4;
    localparam [2:0] S_RBYTE    = 3'h5;
    localparam [2:0] S_RACK     = 3'h6;

    // scales a register code by a measured duty, both out of 255
    // the quotient is floored, so the result may sit one step below the exact value
    function [7:0] bdmc_scale;
        input [7:0]  code;
        input [7:0]  duty;
        reg   [15:0] prod;
        reg   [15:0] quo;
        begin
            prod       = code * duty;
            quo        = prod / 16'h00FF;
            bdmc_scale = quo[7:0]; // quotient never exceeds 255
        end
    endfunction

    // link slave state
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg [7:0] ptr;
    reg       have_ptr;
    reg       rw;
    reg       drive_low;
    reg       scl_q;
    reg       sda_q;
    reg       wr_stb;
    reg [7:0] wr_data;

    // programmed registers and sampled fault inputs
    reg [7:0] duty_level_code;
    reg [7:0] ctrl;
    reg       fault;
    reg       thermal_q;
    reg       overcurr_q;
    reg [7:0] rd_data;

    // sub-block results
    wire [7:0] meas_duty;
    wire       gen_wave;

    // line events; start and stop need the bus clock high on both samples
    wire scl_rise = i_scl & ~scl_q;
    wire scl_fall = ~i_scl & scl_q;
    wire start_c  = scl_q & i_scl & sda_q & ~i_sda;
    wire stop_c   = scl_q & i_scl & ~sda_q & i_sda;

    // control fields
    wire backlight_enable           = ctrl[`BDMC_CTRL_ENABLE];
    wire source_select              = ctrl[`BDMC_CTRL_SOURCE];
    wire dimming_interpretation_bit = ctrl[`BDMC_CTRL_INTERP];

    // open drain: the line is only ever pulled low
    assign o_sda      = 1'b0;
    assign o_sda_oe_n = ~drive_low;

    // read data of the register addressed by the pointer
    // unmapped offsets read as zero, so a stray pointer shows no internal state
    always @* begin
        case (ptr)
            `BDMC_OFS_BRIGHT: rd_data = duty_level_code;
            `BDMC_OFS_CTRL:   rd_data = ctrl;
            `BDMC_OFS_STATUS: rd_data = {4'h0, o_backlight_on_status, overcurr_q,
                                         thermal_q, fault};
            `BDMC_OFS_CHAN:   rd_data = {2'h0, o_channel_on};
            default:          rd_data = 8'h00;
        endcase
    end

    // link sampling; inputs are already synchronous, so one stage is enough for edges
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
        end
    end

    // byte-level slave: address, pointer, then data bytes to the pointed register.
    // reads repeat the pointed register; the pointer does not advance
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state     <= S_IDLE;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            ptr       <= 8'h00;
            have_ptr  <= 1'b0;
            rw        <= 1'b0;
            drive_low <= 1'b0;
            wr_stb    <= 1'b0;
            wr_data   <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (start_c) begin
                state     <= S_ADDR;
                bit_cnt   <= 4'h0;
                drive_low <= 1'b0;
            end else if (stop_c) begin
                state     <= S_IDLE;
                drive_low <= 1'b0;
            end else begin
                case (state)
                    S_IDLE: begin
                        // wait for a start; an unmatched address also parks here
                        drive_low <= 1'b0;
                    end
                    S_ADDR: begin
                        if (scl_rise) begin
                            shreg   <= {shreg[6:0], i_sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            if (shreg[7:1] == BUS_ADDR) begin
                                rw        <= shreg[0];
                                drive_low <= 1'b1;
                                state     <= S_ADDR_ACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_ADDR_ACK: begin
                        // also entered after a host ack to send the next read byte
                        if (scl_fall) begin
                            if (rw) begin
                                drive_low <= ~rd_data[7];
                                shreg     <= {rd_data[6:0], 1'b0};
                                bit_cnt   <= 4'h1;
                                state     <= S_RBYTE;
                            end else begin
                                drive_low <= 1'b0;
                                bit_cnt   <= 4'h0;
                                have_ptr  <= 1'b0;
                                state     <= S_WBYTE;
                            end
                        end
                    end
                    S_WBYTE: begin
                        if (scl_rise) begin
                            shreg   <= {shreg[6:0], i_sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            drive_low <= 1'b1;
                            state     <= S_WACK;
                            if (!have_ptr) begin
                                ptr      <= shreg;
                                have_ptr <= 1'b1;
                            end else begin
                                wr_stb  <= 1'b1;
                                wr_data <= shreg;
                            end
                        end
                    end
                    S_WACK: begin
                        if (scl_fall) begin
                            drive_low <= 1'b0;
                            bit_cnt   <= 4'h0;
                            state     <= S_WBYTE;
                        end
                    end
                    S_RBYTE: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'h8) begin
                                drive_low <= 1'b0;
                                state     <= S_RACK;
                            end else begin
                                drive_low <= ~shreg[7];
                                shreg     <= {shreg[6:0], 1'b0};
                                bit_cnt   <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise)
                            state <= i_sda ? S_IDLE : S_ADDR_ACK;
                    end
                    default: begin
                        state     <= S_IDLE;
                        drive_low <= 1'b0;
                    end
                endcase
            end
        end
    end

    // register file; the brightness code is locked while the external input owns the duty
    // control is kept whole, reserved bits too, so they read back as written
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            duty_level_code <= `BDMC_RST_BRIGHT;
            ctrl            <= `BDMC_RST_CTRL;
        end else if (wr_stb) begin
            if (ptr == `BDMC_OFS_BRIGHT && !source_select)
                duty_level_code <= wr_data;
            if (ptr == `BDMC_OFS_CTRL)
                ctrl <= wr_data;
        end
    end

    // sticky fault; a new fault in the clearing cycle wins over the clear
    // status bits 1 and 2 show the sampled inputs themselves, not a latch
    wire fault_set = thermal_q | overcurr_q;
    wire enable_toggle = wr_stb && ptr == `BDMC_OFS_CTRL &&
                         (wr_data[`BDMC_CTRL_ENABLE] != backlight_enable);
    wire fault_wr0 = wr_stb && ptr == `BDMC_OFS_STATUS && !wr_data[`BDMC_STAT_FAULT];
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fault      <= 1'b0;
            thermal_q  <= 1'b0;
            overcurr_q <= 1'b0;
        end else begin
            thermal_q  <= i_thermal_fault;
            overcurr_q <= i_overcurrent;
            if (fault_set)
                fault <= 1'b1;
            else if (enable_toggle || fault_wr0)
                fault <= 1'b0;
        end
    end

    // backlight state follows the enable one cycle after the write, far inside 4ms
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_backlight_on_status <= 1'b0;
            o_channel_on          <= 6'h00;
        end else begin
            o_backlight_on_status <= backlight_enable;
            o_channel_on          <= backlight_enable ? `BDMC_CHAN_ALL_ON : 6'h00;
        end
    end

    // duty requested of the internal generator: register alone, or register scaled by input
    // the generator latches it at frame start, so a change of interpretation never makes a runt pulse
    wire [7:0] gen_duty = dimming_interpretation_bit ? duty_level_code
                        : bdmc_scale(duty_level_code, meas_duty);

    bdmc_pwm_meas #(
        .MEAS_SHIFT (MEAS_SHIFT)
    ) u_meas (
        .i_core_clk           (i_core_clk),
        .i_arst_n             (i_arst_n),
        .i_external_dim_input (i_external_dim_input),
        .o_duty               (meas_duty)
    );

    bdmc_dim_gen #(
        .TICK_CYC (DIM_TICK_CYC)
    ) u_gen (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_duty     (gen_duty),
        .o_wave     (gen_wave)
    );

    // output selection; direct mode passes the input through to keep its fine resolution
    // zero brightness outranks every mode, so o_dim_out stays low at code 0 while o_channel_on still reads all on
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            o_dim_out <= 1'b0;
        else if (!backlight_enable || duty_level_code == 8'h00)
            o_dim_out <= 1'b0;
        else if (source_select)
            o_dim_out <= i_external_dim_input;
        else
            o_dim_out <= gen_wave;
    end

endmodule

//--- sim/backlight_dimming_mode_control_tb.sv
// self-checking bench for the backlight dimming block
module backlight_dimming_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [15:0] TICK  = 16'h0002;
    localparam int    FRAME = 255 * TICK;
    // design ports
    logic       i_core_clk;
    logic       i_arst_n;
    logic       i_external_dim_input;
    logic       i_thermal_fault;
    logic       i_overcurrent;
    wire        i_scl;
    wire        i_sda;
    wire        sda_drv;
    wire        o_sda;
    wire        o_sda_oe_n;
    wire        o_dim_out;
    wire        o_backlight_on_status;
    wire  [5:0] o_channel_on;
    // bench state
    logic       ext_run;
    int         ext_cnt;
    int         miscompares;
    int         check_count;
    // open-drain data line with a pull-up: low when either side pulls
    assign i_sda = sda_drv & (o_sda_oe_n | o_sda);
    bdmc_top #(.DIM_TICK_CYC(TICK), .MEAS_SHIFT(2)) u_dut (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
        .o_sda_oe_n(o_sda_oe_n), .i_external_dim_input(i_external_dim_input),
        .i_thermal_fault(i_thermal_fault), .i_overcurrent(i_overcurrent), .o_dim_out(o_dim_out),
        .o_backlight_on_status(o_backlight_on_status), .o_channel_on(o_channel_on)
    );
    bdmc_host_model u_host (.i_core_clk(i_core_clk), .i_sda(i_sda), .o_scl(i_scl), .o_sda_drv(sda_drv));
    // 100 MHz core clock
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    // external dimming source, half high over 20 clocks while running
    always @(negedge i_core_clk) begin
        if (ext_run) begin
            ext_cnt <= (ext_cnt + 1) % 20;
            i_external_dim_input <= (ext_cnt < 10);
        end
    end
    // one counted comparison, reported at once on mismatch
    task automatic check(input logic [15:0] seen, exp, input string what);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: saw %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    // register write with its acks checked, register read compared
    task automatic wr(input logic [7:0] ptr, d);
        logic [7:0] q;
        logic       ack_n;
        u_host.xfer(1'b0, ptr, d, q, ack_n);
        check(16'(ack_n), 16'h0000, "write ack");
    endtask
    task automatic rd(input logic [7:0] ptr, exp, input string what);
        logic [7:0] q;
        logic       ack_n;
        u_host.xfer(1'b1, ptr, 8'h00, q, ack_n);
        check(16'(ack_n), 16'h0000, "read ack");
        check(16'(q), 16'(exp), what);
    endtask
    // high clocks and rising edges of the dimming output over n clocks
    task automatic measure(input int n, output int highs, rises);
        logic prev;
        highs = 0;
        rises = 0;
        prev = o_dim_out;
        repeat (n) begin
            @(negedge i_core_clk);
            highs += (o_dim_out === 1'b1);
            rises += (o_dim_out === 1'b1 && prev !== 1'b1);
            prev = o_dim_out;
        end
    endtask
    task automatic t_regs();
        rd(8'h00, 8'hFF, "bright reset");
        rd(8'h01, 8'h00, "ctrl reset");
        rd(8'h05, 8'h00, "unmapped read");
        wr(8'h01, 8'hF8);
        rd(8'h01, 8'hF8, "reserved readback");
        check(16'({o_backlight_on_status, o_channel_on}), 16'h0000, "reserved no effect");
        wr(8'h01, 8'h05);
        rd(8'h01, 8'h05, "ctrl readback");
        check(16'({o_backlight_on_status, o_channel_on}), 16'h007F, "lit state");
        rd(8'h02, 8'h08, "status lit");
        rd(8'h09, 8'h3F, "channels lit");
        wr(8'h01, 8'h04);
        check(16'({o_backlight_on_status, o_channel_on}), 16'h0000, "dark state");
        rd(8'h02, 8'h00, "status dark");
        rd(8'h09, 8'h00, "channels dark");
        $display("test registers done");
    endtask
    // duty from the register alone, boundary codes included
    task automatic t_reg_mode();
        logic [7:0] codes [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
        int         highs;
        int         rises;
        wr(8'h01, 8'h05);
        foreach (codes[i]) begin
            wr(8'h00, codes[i]);
            rd(8'h00, codes[i], "bright readback");
            measure(FRAME + 20, highs, rises);
            measure(2 * FRAME, highs, rises);
            check(16'(highs), 16'(2 * TICK * codes[i]), "register duty");
        end
        $display("test register mode done");
    endtask
    // external input drives the output; brightness writes are dropped
    task automatic t_direct();
        int highs;
        int rises;
        wr(8'h00, 8'h40);
        for (int m = 0; m < 2; m++) begin
            wr(8'h01, m ? 8'h07 : 8'h03);
            wr(8'h00, 8'h10);
            rd(8'h00, 8'h40, "write dropped");
            ext_run = 1'b1;
            measure(20, highs, rises);
            measure(200, highs, rises);
            ext_run = 1'b0;
            check(16'(rises), 16'h000A, "input edges");
            check(16'(highs), 16'h0064, "input high time");
        end
        $display("test direct mode done");
    endtask
    // scaled duty at the internal frame rate; the input rate is far higher
    task automatic t_combined();
        int highs;
        int rises;
        int exp;
        exp = 2 * TICK * 128 * 127 / 255;
        wr(8'h01, 8'h01);
        wr(8'h00, 8'h80);
        ext_run = 1'b1;
        measure(3 * FRAME + 1100, highs, rises);
        measure(2 * FRAME, highs, rises);
        ext_run = 1'b0;
        check(16'(rises), 16'h0002, "frame rate");
        check(16'(highs >= exp - 8 && highs <= exp + 8), 16'h0001, "scaled duty");
        $display("test combined mode done");
    endtask
    // latched fault cleared by a zero write and by an enable toggle
    task automatic t_fault();
        i_thermal_fault = 1'b1;
        repeat (2) @(negedge i_core_clk);
        i_thermal_fault = 1'b0;
        rd(8'h02, 8'h09, "fault latched");
        wr(8'h02, 8'h00);
        rd(8'h02, 8'h08, "fault cleared");
        i_overcurrent = 1'b1;
        repeat (2) @(negedge i_core_clk);
        i_overcurrent = 1'b0;
        rd(8'h02, 8'h09, "fault again");
        wr(8'h01, 8'h00);
        rd(8'h02, 8'h00, "toggle cleared");
        $display("test fault done");
    endtask
    // closing report, the one place the run ends
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // reset for 16 clocks, then the scenarios
    initial begin
        i_arst_n = 1'b0;
        i_external_dim_input = 1'b0;
        i_thermal_fault = 1'b0;
        i_overcurrent = 1'b0;
        ext_run = 1'b0;
        ext_cnt = 0;
        miscompares = 0;
        check_count = 0;
        repeat (16) @(negedge i_core_clk);
        i_arst_n = 1'b1;
        repeat (2) @(negedge i_core_clk);
        t_regs();
        t_reg_mode();
        t_direct();
        t_combined();
        t_fault();
        print_verdict();
    end
    // watchdog well beyond the roughly 23k clocks the scenarios need
    initial begin
        repeat (60000) @(posedge i_core_clk);
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
bind bdmc_top bdmc_chk #(.DIM_TICK_CYC(DIM_TICK_CYC), .MEAS_SHIFT(MEAS_SHIFT), .BUS_ADDR(BUS_ADDR)) u_chk (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
    .o_sda_oe_n(o_sda_oe_n), .i_external_dim_input(i_external_dim_input),
    .i_thermal_fault(i_thermal_fault), .i_overcurrent(i_overcurrent), .o_dim_out(o_dim_out),
    .o_backlight_on_status(o_backlight_on_status), .o_channel_on(o_channel_on)
);

//--- sim/bdmc_chk.sv
// port assertions for the backlight dimming block
`include "bdmc_map.vh"
module bdmc_chk #(
    parameter [15:0] DIM_TICK_CYC = `BDMC_DIM_TICK_CYC,
    parameter        MEAS_SHIFT   = `BDMC_MEAS_SHIFT,
    parameter [6:0]  BUS_ADDR     = `BDMC_BUS_ADDR
) (
    // clock and reset
    input wire       i_core_clk,
    input wire       i_arst_n,
    // host link
    input wire       i_scl,
    input wire       i_sda,
    input wire       o_sda,
    input wire       o_sda_oe_n,
    // dimming side
    input wire       i_external_dim_input,
    input wire       i_thermal_fault,
    input wire       i_overcurrent,
    input wire       o_dim_out,
    input wire       o_backlight_on_status,
    input wire [5:0] o_channel_on
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);
    // backlight off long enough for the gated output to settle
    sequence s_off_settled;
        !o_backlight_on_status [*4];
    endsequence
    // an ack or read bit is pulled for at least 8 core clocks
    sequence s_pull_held;
        !o_sda_oe_n [*8];
    endsequence
    a_chan_when_on: assert property (o_backlight_on_status |-> o_channel_on == 6'h3F)
        else $error("channels not all on while lit");
    a_chan_when_off: assert property (!o_backlight_on_status |-> o_channel_on == 6'h00)
        else $error("channels on while dark");
    a_dim_needs_on: assert property (s_off_settled |-> !o_dim_out)
        else $error("dimming output high while dark");
    a_reset_idle: assert property ($rose(i_arst_n) |-> o_sda_oe_n && !o_dim_out && !o_backlight_on_status)
        else $error("outputs not idle after reset");
    a_status_scl_low: assert property ($changed(o_backlight_on_status) |-> !$past(i_scl) && !$past(i_scl, 2))
        else $error("backlight state moved outside a bus low phase");
    a_oe_scl_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe_n))
        else $error("data line changed while bus clock high");
    a_oe_hold_low: assert property ($fell(o_sda_oe_n) |-> s_pull_held)
        else $error("data line pull too short");
    a_sda_drive_low: assert property (!o_sda_oe_n |-> !o_sda)
        else $error("open drain value not low");
    a_dim_rise_lit: assert property ($rose(o_dim_out) |-> o_backlight_on_status)
        else $error("dimming output rose while dark");
endmodule

//--- sim/bdmc_host_model.sv
// two-wire host model for register reads and writes
`include "bdmc_map.vh"
module bdmc_host_model (
    // line sense
    input  wire  i_core_clk,
    input  wire  i_sda,
    // line drive
    output logic o_scl,
    output logic o_sda_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    // lines idle high from time zero
    initial begin
        o_scl = 1'b1;
        o_sda_drv = 1'b1;
    end
    // every change lands on a falling edge, clear of the sampling edge
    task automatic drive(input logic c, input logic d, input int n);
        o_scl = c;
        o_sda_drv = d;
        repeat (n) @(negedge i_core_clk);
    endtask
    // start or repeated start: data falls while the clock is high
    task automatic bus_start();
        drive(o_scl, 1'b1, 5);
        drive(1'b1, 1'b1, 5);
        drive(1'b1, 1'b0, 5);
        drive(1'b0, 1'b0, 1);
    endtask
    // five low and five high clocks; data held across the fall for hold time
    task automatic bus_bit(input logic b, output logic r);
        drive(1'b0, b, 4);
        drive(1'b1, b, 3);
        r = i_sda;
        drive(1'b1, b, 2);
        drive(1'b0, b, 1);
    endtask
    // msb first; nak high also releases the line for the device ack
    task automatic bus_byte(input logic [7:0] d, input logic nak, output logic [7:0] q, output logic ack_n);
        for (int i = 7; i >= 0; i--) begin
            bus_bit(d[i], q[i]);
        end
        bus_bit(nak, ack_n);
    endtask
    // address, pointer, then one data byte or a repeated start and one read byte
    task automatic xfer(input logic rd, input logic [7:0] ptr, wd, output logic [7:0] q, output logic ack_n);
        logic [2:0] a;
        bus_start();
        bus_byte({`BDMC_BUS_ADDR, 1'b0}, 1'b1, q, a[0]);
        bus_byte(ptr, 1'b1, q, a[1]);
        if (rd) begin
            bus_start();
            bus_byte({`BDMC_BUS_ADDR, 1'b1}, 1'b1, q, a[2]);
            bus_byte(8'hFF, 1'b1, q, ack_n);
        end else begin
            bus_byte(wd, 1'b1, q, a[2]);
        end
        ack_n = |a;
        drive(1'b0, 1'b0, 5);
        drive(1'b1, 1'b0, 5);
        drive(1'b1, 1'b1, 5);
    endtask
endmodule
